// ==== dither_pkg.sv ====
`default_nettype none

package dither_pkg;

    // ------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------
    localparam int CH_COUNT = 8;
    localparam int CODE_W   = 16;
    localparam int FRAME_W  = 32;
    localparam int WAVE_W   = 6;

    typedef logic [CODE_W-1:0]               code_t;
    typedef logic [CH_COUNT-1:0][CODE_W-1:0] code_bus_t;

    // ------------------------------------------------------------
    // Command codes
    // ------------------------------------------------------------
    localparam logic [3:0] CMD_WR_INPUT = 4'h0;
    localparam logic [3:0] CMD_CH_SET   = 4'h1;
    localparam logic [7:0] CMD_AB_SEL   = 8'h72;
    localparam logic [7:0] CMD_SOFT_TOG = 8'h73;
    localparam logic [7:0] CMD_ENABLE   = 8'h74;

    // ------------------------------------------------------------
    // Frame field positions
    // ------------------------------------------------------------
    localparam int CMD_LSB      = 24;
    localparam int ADDR_LSB     = 24;
    localparam int DATA_LSB     = 8;
    localparam int FIELD_BASE   = 8;
    localparam int SET_SRC_LSB  = 8;
    localparam int SET_PH_LSB   = 10;
    localparam int SET_PER_LSB  = 12;
    localparam int SET_MODE_POS = 15;

    // ------------------------------------------------------------
    // Reset values and encodings
    // ------------------------------------------------------------
    localparam logic [7:0]  AB_SEL_RST   = 8'h00;
    localparam logic [7:0]  SOFT_TOG_RST = 8'h00;
    localparam logic [7:0]  ENABLE_RST   = 8'h00;
    localparam logic        MODE_RST     = 1'b0;
    localparam logic [2:0]  PER_RST      = 3'h0;
    localparam logic [1:0]  PH_RST       = 2'h0;
    localparam logic [1:0]  SRC_RST      = 2'h0;
    localparam logic [15:0] CODE_RST     = 16'h0000;
    localparam logic [2:0]  PER_MAX      = 3'h4;
    localparam logic [1:0]  SRC_SOFT     = 2'h0;
    localparam int          SINE_SHIFT   = 6;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_RUN   = 2'b01,
        ST_DRAIN = 2'b11
    } step_state_e;

endpackage : dither_pkg

`default_nettype wire

// ==== wave_stepper.sv ====
`timescale 1ns/100ps
`default_nettype none

module wave_stepper (
    input  wire logic                    clock_i,
    input  wire logic                    rst_i,
    input  wire logic                    step_src_i,
    input  wire logic                    dither_mode_i,
    input  wire logic                    enable_i,
    input  wire logic [2:0]              period_sel_i,
    input  wire logic [1:0]              start_phase_i,
    output logic [dither_pkg::WAVE_W-1:0] index_o,
    output logic                         emit_o,
    output logic                         quiet_o,
    output logic                         busy_o
);
    import dither_pkg::*;

    // ------------------------------------------------------------
    // Period geometry
    // ------------------------------------------------------------
    step_state_e       state_r, state_nxt;
    logic [5:0]        n_r, n_nxt;
    logic [5:0]        first_r, first_nxt;
    logic              src_q_r;
    logic [5:0]        index_nxt;
    logic              emit_nxt;
    logic              quiet_nxt;

    // Codes above the largest period are not allowed; clamp them
    wire  [2:0] per     = (period_sel_i > PER_MAX) ? PER_MAX : period_sel_i;
    wire  [6:0] n_size  = 7'h04 << per;
    wire        last    = (n_r == n_size[5:0] - 6'h01);
    wire  [5:0] quarter = 6'h01 << per;
    wire  [5:0] idx_w   = (n_r << (3'h4 - per))
                          + {start_phase_i, 4'h0};
    wire        rise    = step_src_i & ~src_q_r;
    wire        go      = dither_mode_i & enable_i;

    // ------------------------------------------------------------
    // Step sequencer
    // ------------------------------------------------------------
    always_comb begin
        state_nxt = state_r;
        n_nxt     = n_r;
        first_nxt = first_r;
        index_nxt = index_o;
        emit_nxt  = 1'b0;
        quiet_nxt = quiet_o;
        unique case (state_r)
            ST_IDLE: begin
                if (go) begin
                    state_nxt = ST_RUN;
                    n_nxt     = 6'h00;
                    first_nxt = 6'h00;
                end
            end
            ST_RUN: begin
                if (!go) begin
                    // A finished period may stop at once
                    state_nxt = (n_r == 6'h00) ? ST_IDLE : ST_DRAIN;
                end else if (rise) begin
                    emit_nxt = 1'b1;
                end
            end
            ST_DRAIN: begin
                // Host keeps edges coming until the period closes
                if (!dither_mode_i || (rise && n_r == 6'h00)) begin
                    state_nxt = ST_IDLE;
                end else if (rise) begin
                    emit_nxt = 1'b1;
                end
            end
            default: state_nxt = ST_IDLE;
        endcase
        if (emit_nxt) begin
            index_nxt = idx_w;
            n_nxt     = last ? 6'h00 : n_r + 6'h01;
            quiet_nxt = start_phase_i[0] & (first_r < quarter);
            first_nxt = (first_r == quarter) ? first_r
                                             : first_r + 6'h01;
        end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            state_r <= ST_IDLE;
            n_r     <= 6'h00;
            first_r <= 6'h00;
            src_q_r <= 1'b0;
            index_o <= 6'h00;
            emit_o  <= 1'b0;
            quiet_o <= 1'b0;
            busy_o  <= 1'b0;
        end else begin
            state_r <= state_nxt;
            n_r     <= n_nxt;
            first_r <= first_nxt;
            src_q_r <= step_src_i;
            index_o <= index_nxt;
            emit_o  <= emit_nxt;
            quiet_o <= quiet_nxt;
            busy_o  <= (state_nxt != ST_IDLE);
        end
    end

endmodule : wave_stepper

`default_nettype wire

// ==== toggle_dither_ctrl.sv ====
// Functional notes
// - Code 0x72 loads interleaved write-select bits
// - Select bit picks input register A or B
// - Code 0x73 loads software toggle bits
// - Toggle bits change at strobe rising edge
// - Code 0x74 loads toggle/dither enable bits
// - Toggle channel disabled returns to A immediately
// - Dither channel disabled finishes period first
// - Command 1 writes addressed channel settings
// - Mode bit: 0 toggle, 1 sine dither
// - Period code sets 4 to 64 samples
// - Odd phase: first quarter period gives nothing
// - Source select: soft bit or three pins
// - Don't-care and trailing CRC bits ignored
// - Serial output lags input by 32 edges
// - Serial output released while strobe high
// - Each dither edge: A plus B times sample
// - Sine sequence repeats every N dither edges
`timescale 1ns/100ps
`default_nettype none

module toggle_dither_ctrl (
    input  wire logic            clock_i,
    input  wire logic            rst_i,
    input  wire logic            serial_clk_i,
    input  wire logic            frame_select_load_i,
    input  wire logic            serial_in_i,
    input  wire logic            toggle_pin_zero_i,
    input  wire logic            toggle_pin_one_i,
    input  wire logic            toggle_pin_two_i,
    output logic                 serial_out_o,
    output logic                 serial_out_en_o,
    output dither_pkg::code_bus_t dac_code_o,
    output logic [7:0]           channel_busy_o
);
    import dither_pkg::*;

    // ------------------------------------------------------------
    // Link side: shift register on the serial clock
    // ------------------------------------------------------------
    logic [FRAME_W-1:0] shift_r;
    logic               serial_out_r;

    always_ff @(posedge serial_clk_i or posedge rst_i) begin
        if (rst_i) begin
            shift_r <= '0;
        end else if (!frame_select_load_i) begin
            shift_r <= {shift_r[FRAME_W-2:0], serial_in_i};
        end
    end

    // Driven on the falling edge so the far end samples on rising
    always_ff @(negedge serial_clk_i or posedge rst_i) begin
        if (rst_i) begin
            serial_out_r <= 1'b0;
        end else begin
            serial_out_r <= shift_r[FRAME_W-1];
        end
    end

    assign serial_out_o = serial_out_r;

    // ------------------------------------------------------------
    // Strobe crossing into the system clock
    // ------------------------------------------------------------
    // The serial clock is idle while the strobe is high, so the
    // shift register is stable when the synced edge samples it.
    logic               strobe_m_r;
    logic               strobe_s_r;
    logic               strobe_q_r;
    logic               exec_r;
    logic [FRAME_W-1:0] frame_r;
    logic               oe_r;

    wire strobe_rise = strobe_s_r & ~strobe_q_r;

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            strobe_m_r <= 1'b1;
            strobe_s_r <= 1'b1;
            strobe_q_r <= 1'b1;
        end else begin
            strobe_m_r <= frame_select_load_i;
            strobe_s_r <= strobe_m_r;
            strobe_q_r <= strobe_s_r;
        end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            frame_r <= '0;
            exec_r  <= 1'b0;
        end else begin
            if (strobe_rise) begin
                frame_r <= shift_r;
            end
            exec_r <= strobe_rise;
        end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            oe_r <= 1'b0;
        end else begin
            oe_r <= ~strobe_s_r;
        end
    end

    assign serial_out_en_o = oe_r;

    // ------------------------------------------------------------
    // Toggle pin synchronisers
    // ------------------------------------------------------------
    logic [2:0] pin_m_r;
    logic [2:0] pin_s_r;

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            pin_m_r <= 3'h0;
            pin_s_r <= 3'h0;
        end else begin
            pin_m_r <= {toggle_pin_two_i, toggle_pin_one_i,
                        toggle_pin_zero_i};
            pin_s_r <= pin_m_r;
        end
    end

    // ------------------------------------------------------------
    // Command decode
    // ------------------------------------------------------------
    // The low byte (bits 7:0) is never looked at; the bits between the interleaved positions only by input and settings writes.
    wire [7:0]  cmd      = frame_r[CMD_LSB +: 8];
    wire [3:0]  addr     = frame_r[ADDR_LSB +: 4];
    wire [15:0] data_w   = frame_r[DATA_LSB +: CODE_W];
    wire        addr_ok  = (addr < 4'h8);
    wire        is_input = exec_r && cmd[7:4] == CMD_WR_INPUT;
    wire        is_set   = exec_r && cmd[7:4] == CMD_CH_SET;
    // Unknown codes, no-operation among them, change nothing
    wire        is_ab    = exec_r && cmd == CMD_AB_SEL;
    wire        is_tog   = exec_r && cmd == CMD_SOFT_TOG;
    wire        is_en    = exec_r && cmd == CMD_ENABLE;

    logic [7:0] field_w;

    genvar f;
    generate
        for (f = 0; f < CH_COUNT; f++) begin : g_field
            assign field_w[f] = frame_r[FIELD_BASE + 2*f];
        end
    endgenerate

    // ------------------------------------------------------------
    // Global registers
    // ------------------------------------------------------------
    logic [7:0] ab_sel_r;
    logic [7:0] soft_tog_r;
    logic [7:0] enable_r;

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            ab_sel_r   <= AB_SEL_RST;
            soft_tog_r <= SOFT_TOG_RST;
            enable_r   <= ENABLE_RST;
        end else begin
            if (is_ab) begin
                ab_sel_r <= field_w;
            end
            if (is_tog) begin
                soft_tog_r <= field_w;
            end
            if (is_en) begin
                enable_r <= field_w;
            end
        end
    end

    // ------------------------------------------------------------
    // Sine quarter table, amplitude scaled by 64
    // ------------------------------------------------------------
    function automatic logic [6:0] quarter_sine(input logic [4:0] r);
        logic [6:0] v;
        v = 7'h00;
        unique case (r)
            5'h00:   v = 7'h00;
            5'h01:   v = 7'h06;
            5'h02:   v = 7'h0c;
            5'h03:   v = 7'h12;
            5'h04:   v = 7'h18;
            5'h05:   v = 7'h1e;
            5'h06:   v = 7'h24;
            5'h07:   v = 7'h2a;
            5'h08:   v = 7'h30;
            5'h09:   v = 7'h32;
            5'h0a:   v = 7'h36;
            5'h0b:   v = 7'h38;
            5'h0c:   v = 7'h3c;
            5'h0d:   v = 7'h3e;
            5'h0e:   v = 7'h3e;
            5'h0f:   v = 7'h40;
            default: v = 7'h40;
        endcase
        return v;
    endfunction : quarter_sine

    // Full wave from the quarter table by folding the index
    function automatic logic signed [7:0] sine_of(
        input logic [WAVE_W-1:0] p);
        logic [4:0] r;
        logic [6:0] mag;
        r   = p[4] ? 5'h10 - {1'b0, p[3:0]} : {1'b0, p[3:0]};
        mag = quarter_sine(r);
        return p[5] ? -$signed({1'b0, mag}) : $signed({1'b0, mag});
    endfunction : sine_of

    // ------------------------------------------------------------
    // Per-channel state and output
    // ------------------------------------------------------------
    genvar c;
    generate
        for (c = 0; c < CH_COUNT; c++) begin : g_ch
            code_t       reg_a_r;
            code_t       reg_b_r;
            logic        mode_r;
            logic [2:0]  per_r;
            logic [1:0]  ph_r;
            logic [1:0]  src_sel_r;
            code_t       code_r;
            code_t       code_nxt;
            logic [5:0]  index;
            logic        emit;
            logic        quiet;
            logic        busy;

            wire hit    = addr_ok && addr[2:0] == 3'(c);
            wire wr_in  = is_input && hit;
            wire wr_set = is_set && hit;

            // Source mux: soft bit or one of the synced pins
            wire src = (src_sel_r == SRC_SOFT) ? soft_tog_r[c]
                     : pin_s_r[src_sel_r - 2'h1];

            always_ff @(posedge clock_i or posedge rst_i) begin
                if (rst_i) begin
                    reg_a_r <= CODE_RST;
                    reg_b_r <= CODE_RST;
                end else if (wr_in && ab_sel_r[c]) begin
                    reg_b_r <= data_w;
                end else if (wr_in) begin
                    reg_a_r <= data_w;
                end
            end

            always_ff @(posedge clock_i or posedge rst_i) begin
                if (rst_i) begin
                    mode_r    <= MODE_RST;
                    per_r     <= PER_RST;
                    ph_r      <= PH_RST;
                    src_sel_r <= SRC_RST;
                end else if (wr_set) begin
                    mode_r    <= frame_r[SET_MODE_POS];
                    per_r     <= frame_r[SET_PER_LSB +: 3];
                    ph_r      <= frame_r[SET_PH_LSB +: 2];
                    src_sel_r <= frame_r[SET_SRC_LSB +: 2];
                end
            end

            wave_stepper u_step (
                .clock_i       (clock_i),
                .rst_i         (rst_i),
                .step_src_i    (src),
                .dither_mode_i (mode_r),
                .enable_i      (enable_r[c]),
                .period_sel_i  (per_r),
                .start_phase_i (ph_r),
                .index_o       (index),
                .emit_o        (emit),
                .quiet_o       (quiet),
                .busy_o        (busy)
            );

            // A + B * D(n), with D scaled by 64
            wire signed [7:0]  d_w    = sine_of(index);
            wire signed [24:0] prod_w = $signed({1'b0, reg_b_r})
                                        * d_w;
            wire signed [18:0] sum_w  = $signed({3'b000, reg_a_r})
                                        + prod_w[24:SINE_SHIFT];
            wire        [15:0] dith_w = sum_w[15:0];

            always_comb begin
                code_nxt = code_r;
                if (busy) begin
                    if (emit) begin
                        code_nxt = quiet ? reg_a_r : dith_w;
                    end
                end else if (mode_r) begin
                    code_nxt = reg_a_r;
                end else if (enable_r[c] && src) begin
                    code_nxt = reg_b_r;
                end else begin
                    code_nxt = reg_a_r;
                end
            end

            always_ff @(posedge clock_i or posedge rst_i) begin
                if (rst_i) begin
                    code_r <= CODE_RST;
                end else begin
                    code_r <= code_nxt;
                end
            end

            assign dac_code_o[c]     = code_r;
            assign channel_busy_o[c] = busy;
        end
    endgenerate

endmodule : toggle_dither_ctrl

`default_nettype wire

// ==== dither_monitor.sv ====
`timescale 1ns/100ps
`default_nettype none
// ------------------------------------------------------------
// Port checker
// ------------------------------------------------------------
module dither_monitor (
    input wire logic                  clock_i,
    input wire logic                  rst_i,
    input wire logic                  serial_clk_i,
    input wire logic                  frame_select_load_i,
    input wire logic                  serial_in_i,
    input wire logic                  toggle_pin_zero_i,
    input wire logic                  toggle_pin_one_i,
    input wire logic                  toggle_pin_two_i,
    input wire logic                  serial_out_o,
    input wire logic                  serial_out_en_o,
    input wire dither_pkg::code_bus_t dac_code_o,
    input wire logic [7:0]            channel_busy_o
);
    import dither_pkg::*;
    logic [5:0] edge_cnt_r;
    logic [3:0] quiet_r;
    logic [3:0] prev_r;
    // Any strobe or pin movement restarts the quiet count
    wire logic [3:0] ins_w = {frame_select_load_i, toggle_pin_two_i,
                              toggle_pin_one_i, toggle_pin_zero_i};
    // Saturates so the lag check only runs once history is full
    always_ff @(posedge serial_clk_i or posedge rst_i) begin
        if (rst_i) edge_cnt_r <= 6'h00;
        else if (edge_cnt_r != 6'h21) edge_cnt_r <= edge_cnt_r + 6'h01;
    end
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            prev_r  <= 4'h8;
            quiet_r <= 4'h0;
        end else begin
            prev_r <= ins_w;
            if (ins_w != prev_r) quiet_r <= 4'h0;
            else if (quiet_r != 4'hf) quiet_r <= quiet_r + 4'h1;
        end
    end
    out_hiz_a: assert property (
        @(posedge clock_i) disable iff (rst_i) frame_select_load_i [*5]
        |-> !serial_out_en_o) else $error("output driven while idle");
    out_drive_a: assert property (
        @(posedge clock_i) disable iff (rst_i) !frame_select_load_i [*5]
        |-> serial_out_en_o) else $error("output not driven in frame");
    en_rise_a: assert property (
        @(posedge clock_i) disable iff (rst_i) $rose(serial_out_en_o)
        |-> !frame_select_load_i) else $error("enable rose while idle");
    en_fall_a: assert property (
        @(posedge clock_i) disable iff (rst_i) $fell(serial_out_en_o)
        |-> frame_select_load_i) else $error("enable fell in frame");
    serial_lag_a: assert property (
        @(posedge serial_clk_i) disable iff (rst_i) edge_cnt_r == 6'h21
        |-> serial_out_o == $past(serial_in_i, 32)) else $error("lag wrong");
    out_edge_a: assert property (
        @(posedge clock_i) disable iff (rst_i) $changed(serial_out_o)
        |-> $fell(serial_clk_i)) else $error("output moved off falling edge");
    code_quiet_a: assert property (
        @(posedge clock_i) disable iff (rst_i) quiet_r >= 4'hc
        |-> $stable(dac_code_o)) else $error("code moved without cause");
    busy_quiet_a: assert property (
        @(posedge clock_i) disable iff (rst_i) quiet_r >= 4'hc
        |-> $stable(channel_busy_o)) else $error("busy moved without cause");
    busy_c: cover property (@(posedge clock_i) $rose(channel_busy_o[3]));
    en_c: cover property (@(posedge clock_i) $fell(serial_out_en_o));
    code_c: cover property (@(posedge clock_i) $changed(dac_code_o));
endmodule : dither_monitor
bind toggle_dither_ctrl dither_monitor u_mon (
    .clock_i(clock_i), .rst_i(rst_i), .serial_clk_i(serial_clk_i),
    .frame_select_load_i(frame_select_load_i), .serial_in_i(serial_in_i),
    .toggle_pin_zero_i(toggle_pin_zero_i),
    .toggle_pin_one_i(toggle_pin_one_i), .toggle_pin_two_i(toggle_pin_two_i),
    .serial_out_o(serial_out_o), .serial_out_en_o(serial_out_en_o),
    .dac_code_o(dac_code_o), .channel_busy_o(channel_busy_o));
`default_nettype wire

// ==== spi_host_model.sv ====
`timescale 1ns/100ps
`default_nettype none
// ------------------------------------------------------------
// Serial host: 80 ns link clock, low and still between frames
// ------------------------------------------------------------
module spi_host_model (
    output logic      serial_clk_o,
    output logic      frame_select_load_o,
    output logic      serial_in_o,
    input  wire logic serial_out_i,
    input  wire logic serial_out_en_i
);
    logic [31:0] rx_r;
    // Released output floats up through the chain pull-up
    wire logic line_w = serial_out_en_i ? serial_out_i : 1'b1;
    initial begin
        serial_clk_o        = 1'b0;
        frame_select_load_o = 1'b1;
        serial_in_o         = 1'b0;
        rx_r                = 32'h0;
    end
    task automatic open_frame;
        frame_select_load_o = 1'b0;
        #3;
    endtask : open_frame
    // Most significant bit first; far device's word goes first
    task automatic put_word(input logic [31:0] w);
        for (int i = 31; i >= 0; i--) begin
            serial_in_o = w[i];
            #20 serial_clk_o = 1'b1;
            rx_r = {rx_r[30:0], line_w};
            #40 serial_clk_o = 1'b0;
            #20;
        end
    endtask : put_word
    // One strobe rise runs every word of the chain; gap sets pace
    task automatic close_frame(input int gap);
        frame_select_load_o = 1'b1;
        serial_in_o = ~serial_in_o;
        #(gap);
    endtask : close_frame
endmodule : spi_host_model
`default_nettype wire

// ==== tb_top.sv ====
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin \
    tests_run++; \
    if ((g) !== (e)) begin \
        errors++; \
        $display("BAD %s exp %h got %h", nm, e, g); \
    end \
end
module tb_top;
    import dither_pkg::*;
    logic            clock_i;
    logic            rst_i;
    logic [2:0]      pins;
    wire logic       sclk_w, strobe_w, sdi_w, sdo_w, sdo_en_w;
    wire code_bus_t  code_w;
    wire logic [7:0] busy_w;
    int              errors    = 0;
    int              tests_run = 0;
    int dt [4][5] = '{'{0, 1, 0, -1, 0}, '{0, 0, -1, 0, 0},
                      '{0, -1, 0, 1, 0}, '{0, 0, 1, 0, 0}};
    toggle_dither_ctrl u_dut (
        .clock_i(clock_i), .rst_i(rst_i), .serial_clk_i(sclk_w),
        .frame_select_load_i(strobe_w), .serial_in_i(sdi_w),
        .toggle_pin_zero_i(pins[0]), .toggle_pin_one_i(pins[1]),
        .toggle_pin_two_i(pins[2]), .serial_out_o(sdo_w),
        .serial_out_en_o(sdo_en_w), .dac_code_o(code_w),
        .channel_busy_o(busy_w));
    spi_host_model u_host (
        .serial_clk_o(sclk_w), .frame_select_load_o(strobe_w),
        .serial_in_o(sdi_w), .serial_out_i(sdo_w),
        .serial_out_en_i(sdo_en_w));
    initial begin
        clock_i = 1'b0;
        forever #4 clock_i = ~clock_i;
    end
    function automatic logic [15:0] sprd(input logic [7:0] v);
        sprd = 16'haaaa;
        for (int x = 0; x < 8; x++) sprd[2 * x] = v[x];
    endfunction : sprd
    task automatic cmd(input logic [7:0] c, input logic [15:0] d);
        u_host.open_frame();
        u_host.put_word({c, d, 8'ha5});
        u_host.close_frame(100);
        @(negedge clock_i);
    endtask : cmd
    task automatic set3(input logic m, input logic [2:0] p,
                        input logic [1:0] q, input logic [1:0] s);
        cmd({CMD_CH_SET, 4'h3}, {8'hff, m, p, q, s});
    endtask : set3
    task automatic settle;
        repeat (10) @(negedge clock_i);
    endtask : settle
    task automatic step;
        pins[0] = 1'b1;
        settle();
        pins[0] = 1'b0;
        settle();
    endtask : step
    task automatic t_ab;
        cmd(CMD_AB_SEL, sprd(8'h00));
        cmd({CMD_WR_INPUT, 4'h3}, 16'h1000);
        cmd(CMD_AB_SEL, sprd(8'h08));
        cmd({CMD_WR_INPUT, 4'h3}, 16'h0040);
        cmd({CMD_WR_INPUT, 4'h2}, 16'h2222);
        cmd({CMD_WR_INPUT, 4'h9}, 16'hffff);
        pins = 3'h7;
        settle();
        `CHK("ch3 a", 16'h1000, code_w[3])
        `CHK("ch2 a", 16'h2222, code_w[2])
        `CHK("ch1", 16'h0000, code_w[1])
        pins = 3'h0;
        $display("done select");
    endtask : t_ab
    task automatic t_toggle;
        cmd(CMD_ENABLE, sprd(8'h08));
        `CHK("soft low", 16'h1000, code_w[3])
        cmd(CMD_SOFT_TOG, sprd(8'h08));
        `CHK("soft high", 16'h0040, code_w[3])
        cmd(CMD_ENABLE, sprd(8'h00));
        `CHK("off to a", 16'h1000, code_w[3])
        cmd(CMD_ENABLE, sprd(8'h08));
        `CHK("on again", 16'h0040, code_w[3])
        cmd(CMD_SOFT_TOG, sprd(8'h00));
        `CHK("soft back", 16'h1000, code_w[3])
        $display("done toggle");
    endtask : t_toggle
    task automatic t_source;
        for (int s = 1; s < 4; s++) begin
            set3(1'b0, 3'h0, 2'h0, 2'(s));
            pins = ~(3'h1 << (s - 1));
            settle();
            `CHK("pin off", 16'h1000, code_w[3])
            pins = 3'h1 << (s - 1);
            settle();
            `CHK("pin on", 16'h0040, code_w[3])
        end
        pins = 3'h0;
        cmd(CMD_ENABLE, sprd(8'h00));
        $display("done source");
    endtask : t_source
    task automatic t_phase;
        for (int q = 0; q < 4; q++) begin
            set3(1'b1, 3'h0, 2'(q), 2'h1);
            cmd(CMD_ENABLE, sprd(8'h08));
            for (int k = 0; k < 5; k++) begin
                if (k == 2) cmd(CMD_ENABLE, sprd(8'h00));
                step();
                `CHK("wave", code_t'(4096 + 64 * dt[q][k]), code_w[3])
                `CHK("drain", 1'(k < 4), busy_w[3])
            end
        end
        $display("done phase");
    endtask : t_phase
    task automatic t_period;
        for (int p = 0; p < 5; p++) begin
            set3(1'b1, 3'(p), 2'h0, 2'h1);
            cmd(CMD_ENABLE, sprd(8'h08));
            step();
            cmd(CMD_ENABLE, sprd(8'h00));
            repeat ((4 << p) - 1) step();
            `CHK("period run", 1'b1, busy_w[3])
            step();
            `CHK("period end", 1'b0, busy_w[3])
        end
        $display("done period");
    endtask : t_period
    task automatic t_chain;
        logic [31:0] far;
        far = {CMD_ENABLE, sprd(8'hff), 8'h5a};
        u_host.open_frame();
        u_host.put_word(far);
        u_host.put_word(32'hf000_0000);
        u_host.close_frame(400);
        @(negedge clock_i);
        `CHK("pass far", far, u_host.rx_r)
        step();
        `CHK("noop", 1'b0, busy_w[3])
        u_host.open_frame();
        u_host.put_word(32'hf000_0000);
        u_host.put_word({CMD_ENABLE, sprd(8'h08), 8'h5a});
        u_host.close_frame(400);
        @(negedge clock_i);
        `CHK("pass noop", 32'hf000_0000, u_host.rx_r)
        step();
        `CHK("chain run", 1'b1, busy_w[3])
        $display("done chain");
    endtask : t_chain
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : end_of_test
    // Guard against a hung sequence
    initial begin
        #700000;
        errors++;
        end_of_test();
    end
    initial begin
        rst_i = 1'b1;
        pins  = 3'h0;
        repeat (6) @(negedge clock_i);
        rst_i = 1'b0;
        settle();
        `CHK("reset code", '0, code_w)
        `CHK("reset busy", 8'h00, busy_w)
        `CHK("reset en", 1'b0, sdo_en_w)
        t_ab();
        t_toggle();
        t_source();
        t_phase();
        t_period();
        t_chain();
        end_of_test();
    end
endmodule : tb_top
`default_nettype wire
